// ==== core/ccss_pkg.sv ====
// constants, field positions and state codes for the cpu clock switcher
package ccss_pkg;
  localparam int MAIN_OSC_HALT_POS = 7;
  localparam int CRYSTAL_HALT_POS = 7;
  localparam int RING_OSC_HALT_POS = 0;
  localparam int MAIN_SEL_POS = 0;
  localparam int MAIN_STAT_POS = 1;
  localparam int SUB_SEL_POS = 4;
  localparam int SUB_STAT_POS = 5;
  localparam int DIV_MSB = 2;
  localparam logic [4:0] HOLD_TICKS = 5'h11;
  localparam logic [10:0] LAT_TO_MAIN = 11'h002;
  localparam logic [10:0] LAT_FROM_SUB = 11'h002;
  localparam logic [10:0] LAT_DIV_BASE = 11'h010;
  localparam logic [2:0] DIV_MAX = 3'h4;
  localparam logic [2:0] DIV_RESET = 3'h0;
  localparam logic [7:0] READBACK_RESET = 8'h00;
  typedef enum logic [2:0] {
    CCSS_HOLD = 3'b001,
    CCSS_RUN = 3'b010,
    CCSS_SWITCH = 3'b100
  } ccss_state_t;
endpackage

// ==== core/ccss_switcher.sv ====
// cpu clock source switcher: source select, divider, standby gating
`timescale 1ns/10ps
module ccss_switcher import ccss_pkg::*; #(
  parameter bit RING_STOPPABLE = 1'b1,
  parameter int XP_PER_R = 50,
  parameter int XP_PER_XT = 366
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic ring_tick_i,
  input wire logic main_tick_i,
  input wire logic sub_tick_i,
  input wire logic [7:0] main_osc_ctrl_reg_i,
  input wire logic [7:0] processor_clock_ctrl_i,
  input wire logic [7:0] ring_osc_mode_reg_i,
  input wire logic [7:0] main_clock_mode_reg_i,
  input wire logic stabilization_done_i,
  input wire logic stop_mode_i,
  input wire logic halt_mode_i,
  input wire logic wdt_overflow_i,
  output logic cpu_tick_o,
  output logic periph_tick_o,
  output logic wdt_tick_o,
  output logic internal_reset_o,
  output logic main_osc_run_o,
  output logic ring_osc_run_o,
  output logic sub_osc_run_o,
  output logic prescaler_run_o,
  output logic main_source_status_o,
  output logic subclock_status_o,
  output logic [7:0] main_clock_mode_rd_o,
  output logic [7:0] processor_clock_rd_o
);
  ccss_state_t state_reg, state_next;
  logic src_main_reg, src_sub_reg, tgt_main_reg, tgt_sub_reg;
  logic [2:0] div_reg, tgt_div_reg;
  logic [3:0] div_cnt_reg;
  logic [4:0] hold_cnt_reg;
  logic [10:0] lat_reg, lat_next;

  // field decode
  wire main_osc_halt_bit = main_osc_ctrl_reg_i[MAIN_OSC_HALT_POS];
  wire crystal_halt_bit = processor_clock_ctrl_i[CRYSTAL_HALT_POS];
  wire ring_osc_halt_bit = ring_osc_mode_reg_i[RING_OSC_HALT_POS];
  wire main_source_select = main_clock_mode_reg_i[MAIN_SEL_POS];
  wire subclock_select = processor_clock_ctrl_i[SUB_SEL_POS];
  wire [2:0] cpu_divider = processor_clock_ctrl_i[DIV_MSB:0];

  // ring halt only counts on the stoppable build
  wire ring_halt_eff = RING_STOPPABLE & ring_osc_halt_bit;
  wire on_ring = !src_main_reg && !src_sub_reg;
  // stop is not available while on the subclock
  wire stop_eff = stop_mode_i && !src_sub_reg;
  wire standby = stop_eff || halt_mode_i;

  // subclock is left only toward main, entered only from main
  wire main_wish = src_sub_reg ? 1'b1 : main_source_select;
  // main not taken before stabilization is reported
  wire eff_main = main_wish && (src_main_reg || stabilization_done_i);
  wire eff_sub = subclock_select && src_main_reg && eff_main;
  wire main_chg = eff_main != src_main_reg;
  wire sub_chg = eff_sub != src_sub_reg;
  wire want_switch = main_chg || sub_chg || (cpu_divider != div_reg);

  // latency counted in pre-switch cpu ticks
  wire [2:0] div_lim = (div_reg > DIV_MAX) ? DIV_MAX : div_reg;
  wire [10:0] xpr = 11'(XP_PER_R);
  wire [10:0] xpt2 = 11'(2 * XP_PER_XT);
  wire [10:0] lat_to_ring = (xpr >> div_lim) + 11'h001;
  wire [10:0] lat_to_sub = xpt2 >> div_lim;
  wire [10:0] lat_div = LAT_DIV_BASE >> div_lim;
  wire [10:0] lat_raw = main_chg ? (src_main_reg ? lat_to_ring : LAT_TO_MAIN)
                      : (eff_sub && !src_sub_reg) ? lat_to_sub
                      : (!eff_sub && src_sub_reg) ? LAT_FROM_SUB : lat_div;
  wire [10:0] lat_start = (lat_raw == 11'h000) ? 11'h001 : lat_raw;

  // cpu tick from the active source, through the divider except on the subclock
  wire src_tick = src_sub_reg ? sub_tick_i
                : src_main_reg ? main_tick_i : ring_tick_i;
  wire [4:0] mask_w = (5'h01 << div_lim) - 5'h01;
  wire [3:0] div_mask = mask_w[3:0];
  wire div_hit = src_sub_reg || ((div_cnt_reg & div_mask) == div_mask);
  wire cpu_en = src_tick && div_hit && !standby && state_reg != CCSS_HOLD;
  wire apply = state_reg == CCSS_SWITCH && cpu_en && lat_reg == 11'h001;

  // prescaler follows main select in halt
  wire periph_sel_main = halt_mode_i ? main_source_select
                       : (src_main_reg || src_sub_reg);
  wire periph_en = !stop_eff && state_reg != CCSS_HOLD &&
                   (periph_sel_main ? main_tick_i : ring_tick_i);
  // wdt: free on unstoppable ring, else gated in standby
  wire wdt_en = ring_tick_i && (!RING_STOPPABLE || !standby);
  // main crystal keeps running while used or targeted
  // status stays 1 on the subclock, so the sub flags must be excluded
  wire main_keep = (src_main_reg && !src_sub_reg) ||
                   (state_reg == CCSS_SWITCH && tgt_main_reg && !tgt_sub_reg);
  // halt source depends on cpu source
  wire main_halt_req = src_sub_reg ? crystal_halt_bit : main_osc_halt_bit;
  wire main_run = !stop_eff && (main_keep || !main_halt_req);
  // ring cannot stop while it clocks the cpu
  wire ring_run = !ring_halt_eff || (on_ring && !stop_eff);

  always_comb begin
    state_next = state_reg;
    lat_next = lat_reg;
    unique case (state_reg)
      CCSS_HOLD: begin
        // cpu clock withheld for 17 ring ticks
        if (ring_tick_i && hold_cnt_reg == HOLD_TICKS - 5'h01) begin
          state_next = CCSS_RUN;
        end
      end
      CCSS_RUN: begin
        // switching frozen in standby
        if (want_switch && !standby) begin
          state_next = CCSS_SWITCH;
          lat_next = lat_start;
        end
      end
      CCSS_SWITCH: begin
        // old clock runs until the count ends
        if (apply) begin
          state_next = CCSS_RUN;
        end else if (cpu_en) begin
          lat_next = lat_reg - 11'h001;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_reg <= CCSS_HOLD;
      lat_reg <= 11'h000;
      hold_cnt_reg <= 5'h00;
    end else begin
      state_reg <= state_next;
      lat_reg <= lat_next;
      if (state_reg == CCSS_HOLD && ring_tick_i) begin
        hold_cnt_reg <= hold_cnt_reg + 5'h01;
      end
    end
  end

  // target latched at switch start; later writes wait their turn
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      tgt_main_reg <= 1'b0;
      tgt_sub_reg <= 1'b0;
      tgt_div_reg <= DIV_RESET;
    end else if (state_reg == CCSS_RUN && state_next == CCSS_SWITCH) begin
      tgt_main_reg <= eff_main;
      tgt_sub_reg <= eff_sub;
      tgt_div_reg <= cpu_divider;
    end
  end

  // change lands on a tick and restarts the divider
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      src_main_reg <= 1'b0;
      src_sub_reg <= 1'b0;
      div_reg <= DIV_RESET;
      div_cnt_reg <= 4'h0;
    end else if (apply) begin
      src_main_reg <= tgt_main_reg;
      src_sub_reg <= tgt_sub_reg;
      div_reg <= tgt_div_reg;
      div_cnt_reg <= 4'h0;
    end else if (src_tick && !standby) begin
      div_cnt_reg <= div_hit ? 4'h0 : div_cnt_reg + 4'h1;
    end
  end

  // reset: main and ring off, sub on, prescaler off
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cpu_tick_o <= 1'b0;
      periph_tick_o <= 1'b0;
      wdt_tick_o <= 1'b0;
      internal_reset_o <= 1'b0;
      main_osc_run_o <= 1'b0;
      ring_osc_run_o <= 1'b0;
      sub_osc_run_o <= 1'b1;
      prescaler_run_o <= 1'b0;
      main_clock_mode_rd_o <= READBACK_RESET;
      processor_clock_rd_o <= READBACK_RESET;
    end else begin
      cpu_tick_o <= cpu_en;
      periph_tick_o <= periph_en;
      wdt_tick_o <= wdt_en;
      internal_reset_o <= wdt_overflow_i;
      main_osc_run_o <= main_run;
      ring_osc_run_o <= ring_run;
      sub_osc_run_o <= 1'b1;
      prescaler_run_o <= !stop_eff;
      main_clock_mode_rd_o <= {6'h00, src_main_reg, main_source_select};
      processor_clock_rd_o <= {processor_clock_ctrl_i[7:6], src_sub_reg,
                               processor_clock_ctrl_i[4:0]};
    end
  end

  assign main_source_status_o = src_main_reg;
  assign subclock_status_o = src_sub_reg;

  property p_boot_ring;
    @(posedge core_clk_i) $fell(reset_i) |->
      !src_main_reg && !main_osc_run_o && sub_osc_run_o;
  endproperty
  a_boot_ring: assert property (p_boot_ring)
    else $error("reset did not leave ring as source");
  property p_hold;
    @(posedge core_clk_i) disable iff (reset_i)
      state_reg == CCSS_HOLD |=> !cpu_tick_o;
  endproperty
  a_hold: assert property (p_hold)
    else $error("cpu ticked during hold");
  property p_stop_presc;
    @(posedge core_clk_i) disable iff (reset_i)
      stop_eff |=> !prescaler_run_o && !periph_tick_o && !cpu_tick_o;
  endproperty
  a_stop_presc: assert property (p_stop_presc)
    else $error("clock ran in stop");
  property p_ring_fixed;
    @(posedge core_clk_i) disable iff (reset_i)
      !RING_STOPPABLE |=> ring_osc_run_o;
  endproperty
  a_ring_fixed: assert property (p_ring_fixed)
    else $error("unstoppable ring stopped");
  property p_sub_via_main;
    @(posedge core_clk_i) disable iff (reset_i)
      subclock_status_o |-> main_source_status_o;
  endproperty
  a_sub_via_main: assert property (p_sub_via_main)
    else $error("subclock reached from ring");
  property p_main_kept;
    @(posedge core_clk_i) disable iff (reset_i)
      src_main_reg && !src_sub_reg && !stop_eff |=> main_osc_run_o;
  endproperty
  a_main_kept: assert property (p_main_kept)
    else $error("main crystal stopped while in use");
  property p_to_main_lat;
    @(posedge core_clk_i) disable iff (reset_i)
      state_reg == CCSS_RUN && !standby && want_switch && main_chg &&
      !src_main_reg |=> lat_reg == 11'h002;
  endproperty
  a_to_main_lat: assert property (p_to_main_lat)
    else $error("ring to main latency not 2");
  property p_div_lat;
    @(posedge core_clk_i) disable iff (reset_i)
      state_reg == CCSS_RUN && !standby && want_switch && !main_chg &&
      !sub_chg && !src_sub_reg |=> lat_reg == (11'h010 >> $past(div_lim));
  endproperty
  a_div_lat: assert property (p_div_lat)
    else $error("divider latency wrong");
  property p_status_late;
    @(posedge core_clk_i) disable iff (reset_i)
      $changed(src_main_reg) |-> $past(cpu_en) && $past(lat_reg) == 11'h001;
  endproperty
  a_status_late: assert property (p_status_late)
    else $error("status changed before latency ended");
  property p_standby_freeze;
    @(posedge core_clk_i) disable iff (reset_i)
      standby |=> $stable(src_main_reg) && $stable(src_sub_reg);
  endproperty
  a_standby_freeze: assert property (p_standby_freeze)
    else $error("source moved in standby");
  property p_wdt_stop;
    @(posedge core_clk_i) disable iff (reset_i)
      !RING_STOPPABLE && ring_tick_i |=> wdt_tick_o;
  endproperty
  a_wdt_stop: assert property (p_wdt_stop)
    else $error("watchdog tick lost");
  c_to_main: cover property (@(posedge core_clk_i) $rose(src_main_reg));
  c_to_sub: cover property (@(posedge core_clk_i) $rose(src_sub_reg));
  c_stop: cover property (@(posedge core_clk_i) $rose(stop_eff));
  c_div: cover property (@(posedge core_clk_i) apply && div_reg != tgt_div_reg);
endmodule // ccss_switcher

// ==== tb/tb_top.sv ====
// self-checking testbench for the cpu clock source switcher
`timescale 1ns/10ps
module tb_top import ccss_pkg::*;;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ring_tick_i = 1'b0, main_tick_i = 1'b0, sub_tick_i = 1'b0;
  logic [7:0] main_osc_ctrl_reg_i = 8'h00, processor_clock_ctrl_i = 8'h00;
  logic [7:0] ring_osc_mode_reg_i = 8'h00, main_clock_mode_reg_i = 8'h00;
  logic stabilization_done_i = 1'b0, stop_mode_i = 1'b0;
  logic halt_mode_i = 1'b0, wdt_overflow_i = 1'b0;
  logic cpu_tick_o, periph_tick_o, wdt_tick_o, internal_reset_o;
  logic main_osc_run_o, ring_osc_run_o, sub_osc_run_o, prescaler_run_o;
  logic main_source_status_o, subclock_status_o;
  logic [7:0] main_clock_mode_rd_o, processor_clock_rd_o;
  logic fx_ring_run, fx_wdt_tick, fx_int_reset, early = 1'b0;
  int errors = 0, checks = 0, tick_cnt = 0, ring_seen = 0;

  always #20 core_clk_i = ~core_clk_i;

  // source ticks at unrelated rates so selection errors show in counts
  always @(posedge core_clk_i) begin
    tick_cnt <= tick_cnt + 1;
    ring_tick_i <= (tick_cnt % 2 == 0);
    main_tick_i <= (tick_cnt % 3 == 0);
    sub_tick_i <= (tick_cnt % 5 == 0);
  end

  always @(posedge core_clk_i) begin
    if (reset_i) ring_seen <= 0;
    else if (ring_tick_i) ring_seen <= ring_seen + 1;
    if (!reset_i && cpu_tick_o === 1'b1 && ring_seen < 17) early <= 1'b1;
  end

  // default build: ring oscillator stoppable
  ccss_switcher #(.XP_PER_R(4), .XP_PER_XT(8)) DUT (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .ring_tick_i(ring_tick_i),
    .main_tick_i(main_tick_i), .sub_tick_i(sub_tick_i),
    .main_osc_ctrl_reg_i(main_osc_ctrl_reg_i),
    .processor_clock_ctrl_i(processor_clock_ctrl_i),
    .ring_osc_mode_reg_i(ring_osc_mode_reg_i),
    .main_clock_mode_reg_i(main_clock_mode_reg_i),
    .stabilization_done_i(stabilization_done_i), .stop_mode_i(stop_mode_i),
    .halt_mode_i(halt_mode_i), .wdt_overflow_i(wdt_overflow_i),
    .cpu_tick_o(cpu_tick_o), .periph_tick_o(periph_tick_o),
    .wdt_tick_o(wdt_tick_o), .internal_reset_o(internal_reset_o),
    .main_osc_run_o(main_osc_run_o), .ring_osc_run_o(ring_osc_run_o),
    .sub_osc_run_o(sub_osc_run_o), .prescaler_run_o(prescaler_run_o),
    .main_source_status_o(main_source_status_o),
    .subclock_status_o(subclock_status_o),
    .main_clock_mode_rd_o(main_clock_mode_rd_o),
    .processor_clock_rd_o(processor_clock_rd_o));

  // same stimulus, ring oscillator built as unstoppable
  ccss_switcher #(.RING_STOPPABLE(1'b0), .XP_PER_R(4), .XP_PER_XT(8))
      DUT_FIXED (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .ring_tick_i(ring_tick_i),
    .main_tick_i(main_tick_i), .sub_tick_i(sub_tick_i),
    .main_osc_ctrl_reg_i(main_osc_ctrl_reg_i),
    .processor_clock_ctrl_i(processor_clock_ctrl_i),
    .ring_osc_mode_reg_i(ring_osc_mode_reg_i),
    .main_clock_mode_reg_i(main_clock_mode_reg_i),
    .stabilization_done_i(stabilization_done_i), .stop_mode_i(stop_mode_i),
    .halt_mode_i(halt_mode_i), .wdt_overflow_i(wdt_overflow_i),
    .cpu_tick_o(), .periph_tick_o(), .wdt_tick_o(fx_wdt_tick),
    .internal_reset_o(fx_int_reset), .main_osc_run_o(),
    .ring_osc_run_o(fx_ring_run), .sub_osc_run_o(), .prescaler_run_o(),
    .main_source_status_o(), .subclock_status_o(),
    .main_clock_mode_rd_o(), .processor_clock_rd_o());

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  task wait_stat(input logic on_sub, input logic v);
    for (int i = 0; i < 400; i++) begin
      if ((on_sub ? subclock_status_o : main_source_status_o) === v) break;
      @(negedge core_clk_i);
    end
  endtask

  // counts main ticks and the cpu ticks they cause over 30 cycles
  task cnt_main(output int nsrc, output int ncpu);
    nsrc = 0;
    ncpu = 0;
    for (int j = 0; j <= 30; j++) begin
      if (j < 30 && main_tick_i === 1'b1) nsrc++;
      if (j > 0 && cpu_tick_o === 1'b1) ncpu++;
      cyc(1);
    end
  endtask

  task t_reset();
    repeat (7) @(posedge core_clk_i);
    cyc(1);
    chk({sub_osc_run_o, main_osc_run_o, ring_osc_run_o, prescaler_run_o},
        8'h08);
    @(posedge core_clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 100 && cpu_tick_o !== 1'b1; i++) cyc(1);
    chk(cpu_tick_o, 8'h01);
    chk(early, 8'h00);
    chk(main_clock_mode_rd_o, 8'h00);
  endtask

  task t_to_main();
    @(posedge core_clk_i);
    main_clock_mode_reg_i[MAIN_SEL_POS] <= 1'b1;
    cyc(20);
    chk(main_source_status_o, 8'h00);
    @(posedge core_clk_i);
    stabilization_done_i <= 1'b1;
    cyc(2);
    chk(main_source_status_o, 8'h00);
    wait_stat(1'b0, 1'b1);
    cyc(2);
    chk(main_clock_mode_rd_o, 8'h03);
    @(posedge core_clk_i);
    main_osc_ctrl_reg_i <= 8'h80;
    processor_clock_ctrl_i <= 8'h80;
    cyc(4);
    chk(main_osc_run_o, 8'h01);
    @(posedge core_clk_i);
    main_osc_ctrl_reg_i <= 8'h00;
    processor_clock_ctrl_i <= 8'h00;
  endtask

  // divider 001 on main: old rate during latency, half rate after
  task t_div();
    int nsrc, ncpu;
    @(posedge core_clk_i);
    processor_clock_ctrl_i <= 8'h01;
    cyc(1);
    cnt_main(nsrc, ncpu);
    chk(8'(ncpu), 8'(nsrc));
    cyc(60);
    cnt_main(nsrc, ncpu);
    chk(8'(ncpu), 8'(nsrc / 2));
    @(posedge core_clk_i);
    processor_clock_ctrl_i <= 8'h00;
    cyc(80);
  endtask

  task t_sub();
    @(posedge core_clk_i);
    processor_clock_ctrl_i <= 8'h10;
    cyc(2);
    chk(subclock_status_o, 8'h00);
    wait_stat(1'b1, 1'b1);
    cyc(2);
    chk(processor_clock_rd_o, 8'h30);
    // illegal ring request and crystal halt while on subclock
    @(posedge core_clk_i);
    main_clock_mode_reg_i <= 8'h00;
    processor_clock_ctrl_i <= 8'h90;
    cyc(40);
    chk({subclock_status_o, main_source_status_o, main_osc_run_o},
        8'h06);
    @(posedge core_clk_i);
    main_clock_mode_reg_i <= 8'h01;
    processor_clock_ctrl_i <= 8'h00;
    wait_stat(1'b1, 1'b0);
    cyc(2);
    chk({subclock_status_o, main_source_status_o}, 8'h01);
  endtask

  task t_halt(input logic sel);
    int nsrc, nper;
    nsrc = 0;
    nper = 0;
    @(posedge core_clk_i);
    main_clock_mode_reg_i <= {7'h00, sel};
    wait_stat(1'b0, sel);
    @(posedge core_clk_i);
    halt_mode_i <= 1'b1;
    cyc(4);
    for (int j = 0; j <= 30; j++) begin
      if (j < 30 && (sel ? main_tick_i : ring_tick_i)) nsrc++;
      if (j > 0 && periph_tick_o === 1'b1) nper++;
      cyc(1);
    end
    chk(8'(nper), 8'(nsrc));
    @(posedge core_clk_i);
    halt_mode_i <= 1'b0;
    cyc(4);
    chk(main_source_status_o, {7'h00, sel});
  endtask

  task t_ring_main_osc();
    @(posedge core_clk_i);
    processor_clock_ctrl_i <= 8'h80;
    cyc(4);
    chk(main_osc_run_o, 8'h01);
    @(posedge core_clk_i);
    processor_clock_ctrl_i <= 8'h00;
    main_osc_ctrl_reg_i <= 8'h80;
    cyc(4);
    chk(main_osc_run_o, 8'h00);
    @(posedge core_clk_i);
    main_osc_ctrl_reg_i <= 8'h00;
  endtask

  task t_stop();
    int nwdt, nwdt_s;
    nwdt = 0;
    nwdt_s = 0;
    // main halt bit stays 0 while ring halt is set
    @(posedge core_clk_i);
    ring_osc_mode_reg_i <= 8'h01;
    stop_mode_i <= 1'b1;
    cyc(4);
    chk({prescaler_run_o, ring_osc_run_o, fx_ring_run},
        8'h01);
    repeat (20) begin
      cyc(1);
      if (fx_wdt_tick === 1'b1) nwdt++;
      if (wdt_tick_o !== 1'b0) nwdt_s++;
    end
    chk(nwdt > 0, 8'h01);
    chk(8'(nwdt_s), 8'h00);
    @(posedge core_clk_i);
    ring_osc_mode_reg_i <= 8'h00;
    wdt_overflow_i <= 1'b1;
    @(posedge core_clk_i);
    wdt_overflow_i <= 1'b0;
    cyc(1);
    chk({internal_reset_o, fx_int_reset}, 8'h03);
    cyc(2);
    chk(ring_osc_run_o, 8'h01);
    @(posedge core_clk_i);
    stop_mode_i <= 1'b0;
    cyc(4);
    chk(main_source_status_o, 8'h00);
  endtask

  task results();
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    t_reset();
    t_to_main();
    t_div();
    t_sub();
    t_halt(1'b1);
    t_halt(1'b0);
    t_ring_main_osc();
    t_stop();
    results();
  end

  // whole sequence needs a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge core_clk_i);
    errors++;
    results();
  end
endmodule // tb_top
